/* File: core/ivp_top.sv */
// ivp_top: reset and interrupt vector address generation
// assumes: core presents pending enabled requests as levels and takes o_vec_valid
// assumes: control writes arrive as one-cycle strobes with data; fuse is static
`timescale 1ns/1ps
`include "ivp_consts.svh"
// Behaviour
// [RULE1] every reset cause sends execution to word zero when fuse unprogrammed
// [RULE2] controller capture/end-cycle to 1..6, comparators to 7..9
// [RULE3] external requests 0..3 to 0x0A, 0x13, 0x18, 0x1C
// [RULE4] 16-bit timer capture/compares to 0x0B..0x0D, overflow 0x0F, 0x0E unused
// [RULE5] 8-bit timer compare A 0x10, overflow 0x11, compare B 0x1B
// [RULE6] SPI 0x14, USART receive/empty/transmit 0x15..0x17
// [RULE7] ADC 0x12, watchdog 0x19, EEPROM 0x1A, store ready 0x1F; 0x1D,0x1E unused
// [RULE8] programmed fuse starts execution at boot reset address
// [RULE9] relocation adds boot section start to each vector
// [RULE10] reset and table start follow fuse and relocation combinations
// [RULE11] software may place code in vectors never fetched
// [RULE12] lowest pending vector address wins dispatch
// [RULE13] software sets unlock, then writes relocation within four cycles
// [RULE14] dispatch blocked from unlock until after following instruction or four cycles
module ivp_top #(
  parameter logic [`IVP_ADDR_W-1:0] BOOT_RESET_ADDR = `IVP_BOOT_RESET_ADDR,
  parameter int UNLOCK_CYCLES = `IVP_UNLOCK_CYCLES
) (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_boot_reset_select_fuse,
  input wire logic i_ctrl_wr,
  input wire logic [7:0] i_ctrl_wdata,
  input wire logic i_instr_done,
  input wire logic [`IVP_NUM_SRC-1:0] i_irq_pending,
  output logic [7:0] o_mcu_control_register,
  output logic [`IVP_ADDR_W-1:0] o_reset_vector,
  output logic o_vec_valid,
  output logic [`IVP_ADDR_W-1:0] o_vec_addr,
  output logic [4:0] o_vec_slot,
  output logic o_irq_blocked
);
  localparam logic [`IVP_NUM_SRC-1:0] SLOT_MASK = ~(`IVP_SLOT_UNUSED | 32'h00000001);
  localparam logic [2:0] CNT_INIT = 3'(UNLOCK_CYCLES - 1);
  localparam logic [7:0] CTRL_RST = `IVP_CTRL_RESET;
  ivp_pkg::ivp_state_type state_r;
  logic reloc_r;
  logic unlock_r;
  logic [2:0] cnt_r;
  logic fuse_r;
  logic [`IVP_ADDR_W-1:0] vec_addr_r;
  logic [4:0] vec_slot_r;
  logic blocked;
  ivp_prio_if prio ();
  ivp_prio_enc u_enc (.prio(prio));
  function automatic logic [`IVP_ADDR_W-1:0] ivp_vec(input logic [4:0] slot, input logic rel,
                                                    input logic [`IVP_ADDR_W-1:0] boot);
    logic [`IVP_ADDR_W-1:0] base;
    base = {{(`IVP_ADDR_W-5){1'b0}}, slot};
    return rel ? `IVP_ADDR_W'(base + boot) : base; // RULE9
  endfunction
  // fuse caught after reset release
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      fuse_r <= 1'b1;
    end else begin
      fuse_r <= i_boot_reset_select_fuse;
    end
  end
  // reset vector placement
  always_comb begin
    o_reset_vector = fuse_r ? `IVP_RESET_VEC : BOOT_RESET_ADDR; // RULE1 RULE8 RULE10
  end
  // unlock sequence and relocation bit
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_r <= ivp_pkg::IVP_ST_IDLE;
      reloc_r <= CTRL_RST[`IVP_RELOC_BIT];
      unlock_r <= CTRL_RST[`IVP_UNLOCK_BIT];
      cnt_r <= 3'h0;
    end else begin
      unique case (state_r)
        ivp_pkg::IVP_ST_IDLE: begin
          if (i_ctrl_wr && i_ctrl_wdata[`IVP_UNLOCK_BIT]) begin
            state_r <= ivp_pkg::IVP_ST_UNLOCKED;
            unlock_r <= 1'b1;
            cnt_r <= CNT_INIT;
          end
        end
        ivp_pkg::IVP_ST_UNLOCKED: begin
          if (i_ctrl_wr && !i_ctrl_wdata[`IVP_UNLOCK_BIT]) begin
            reloc_r <= i_ctrl_wdata[`IVP_RELOC_BIT]; // RULE13
            unlock_r <= 1'b0;
            state_r <= ivp_pkg::IVP_ST_HOLDOFF;
          end else if (cnt_r == 3'h0) begin
            unlock_r <= 1'b0; // RULE14
            state_r <= ivp_pkg::IVP_ST_IDLE;
          end else begin
            cnt_r <= cnt_r - 3'h1;
          end
        end
        ivp_pkg::IVP_ST_HOLDOFF: begin
          if (i_instr_done) begin
            state_r <= ivp_pkg::IVP_ST_IDLE; // RULE14
          end
        end
        default: begin
          state_r <= ivp_pkg::IVP_ST_IDLE;
          unlock_r <= 1'b0;
        end
      endcase
    end
  end
  assign blocked = (state_r != ivp_pkg::IVP_ST_IDLE)
                   || (i_ctrl_wr && i_ctrl_wdata[`IVP_UNLOCK_BIT]); // RULE14
  assign o_irq_blocked = blocked;
  assign o_mcu_control_register = {6'h00, reloc_r, unlock_r};
  // unassigned slots and reset slot never dispatch
  assign prio.req = i_irq_pending & SLOT_MASK; // RULE4 RULE7 RULE12
  // dispatch register
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_vec_valid <= 1'b0;
      vec_addr_r <= `IVP_TABLE_BASE;
      vec_slot_r <= 5'h00;
    end else begin
      o_vec_valid <= prio.found && !blocked;
      if (prio.found && !blocked) begin
        vec_slot_r <= prio.slot; // RULE2 RULE3 RULE5 RULE6
        vec_addr_r <= ivp_vec(prio.slot, reloc_r, BOOT_RESET_ADDR); // RULE10
      end
    end
  end
  assign o_vec_addr = vec_addr_r;
  assign o_vec_slot = vec_slot_r;
  // checks
  property p_reset_vec;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    $past(i_reset_n) |-> o_reset_vector == ($past(i_boot_reset_select_fuse) ? 12'h000
                                                                            : BOOT_RESET_ADDR);
  endproperty
  a_reset_vec: assert property (p_reset_vec) else $error("reset vector wrong"); // RULE1 RULE8
  property p_addr;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    o_vec_valid |-> o_vec_addr == ($past(reloc_r) ? 12'(o_vec_slot + BOOT_RESET_ADDR)
                                                 : {7'h00, o_vec_slot});
  endproperty
  a_addr: assert property (p_addr) else $error("vector address wrong"); // RULE9
  property p_unused;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    o_vec_valid |-> !(o_vec_slot inside {5'h00, 5'h0E, 5'h1D, 5'h1E});
  endproperty
  a_unused: assert property (p_unused) else $error("unused slot dispatched"); // RULE7
  property p_lowest;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    o_vec_valid |-> (($past(prio.req) & ((32'h1 << o_vec_slot) - 32'h1)) == 32'h0);
  endproperty
  a_lowest: assert property (p_lowest) else $error("not lowest pending"); // RULE12
  property p_block;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    (state_r == ivp_pkg::IVP_ST_IDLE && i_ctrl_wr && i_ctrl_wdata[0]) |=> !o_vec_valid;
  endproperty
  a_block: assert property (p_block) else $error("dispatch during unlock"); // RULE14
  property p_timeout;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    (state_r == ivp_pkg::IVP_ST_IDLE && i_ctrl_wr && i_ctrl_wdata[0]
     ##1 !i_ctrl_wr [*4]) |=> state_r == ivp_pkg::IVP_ST_IDLE;
  endproperty
  a_timeout: assert property (p_timeout) else $error("unlock not ended in four"); // RULE14
  property p_reloc_locked;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    (state_r == ivp_pkg::IVP_ST_IDLE) |=> $stable(reloc_r);
  endproperty
  a_reloc_locked: assert property (p_reloc_locked) else $error("relocation changed unlocked"); // RULE13
  property p_ext0;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    (!blocked && prio.req[10] && prio.req[9:0] == 10'h000) |=> o_vec_slot == 5'h0A;
  endproperty
  a_ext0: assert property (p_ext0) else $error("external request 0 slot wrong"); // RULE3
  // slot map and lockout checks
  property p_unlock_clear;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    $rose(unlock_r) |-> ##[1:4] !unlock_r;
  endproperty
  a_unlock_clear: assert property (p_unlock_clear) else $error("unlock bit held too long"); // RULE14
  property p_table_start;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    (!blocked && prio.req[1]) |=> o_vec_valid
      && o_vec_addr == ($past(reloc_r) ? 12'(BOOT_RESET_ADDR + 12'h001) : `IVP_TABLE_BASE);
  endproperty
  a_table_start: assert property (p_table_start) else $error("table start wrong"); // RULE10
  property p_spm_slot;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    (!blocked && i_irq_pending == 32'h80000000) |=> o_vec_valid && o_vec_slot == 5'h1F;
  endproperty
  a_spm_slot: assert property (p_spm_slot) else $error("store ready slot wrong"); // RULE7
  property p_comp_slot;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    (!blocked && i_irq_pending == 32'h00000080) |=> o_vec_valid && o_vec_slot == 5'h07;
  endproperty
  a_comp_slot: assert property (p_comp_slot) else $error("comparator 0 slot wrong"); // RULE2
  property p_no_unused;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    (i_irq_pending == 32'h00004000) |=> !o_vec_valid;
  endproperty
  a_no_unused: assert property (p_no_unused) else $error("empty timer slot dispatched"); // RULE4
  property p_reset_slot;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    (i_irq_pending == 32'h00000001) |=> !o_vec_valid;
  endproperty
  a_reset_slot: assert property (p_reset_slot) else $error("reset slot dispatched"); // RULE1
  property p_reloc_write;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    (state_r == ivp_pkg::IVP_ST_UNLOCKED && i_ctrl_wr && !i_ctrl_wdata[`IVP_UNLOCK_BIT])
      |=> reloc_r == $past(i_ctrl_wdata[`IVP_RELOC_BIT]);
  endproperty
  a_reloc_write: assert property (p_reloc_write) else $error("relocation write lost"); // RULE13
  property p_no_dispatch_locked;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    (state_r != ivp_pkg::IVP_ST_IDLE) |=> !o_vec_valid;
  endproperty
  a_no_dispatch_locked: assert property (p_no_dispatch_locked) else $error("dispatch while locked"); // RULE14
  c_reloc: cover property (@(posedge i_clk_sys) o_vec_valid && reloc_r);
  c_timeout: cover property (@(posedge i_clk_sys) state_r == ivp_pkg::IVP_ST_UNLOCKED && cnt_r == 3'h0);
  c_prog: cover property (@(posedge i_clk_sys) o_reset_vector == BOOT_RESET_ADDR);
  c_seq: cover property (@(posedge i_clk_sys) state_r == ivp_pkg::IVP_ST_HOLDOFF);
  c_spm: cover property (@(posedge i_clk_sys) o_vec_valid && o_vec_slot == 5'h1F);
endmodule // ivp_top

/* File: core/ivp_consts.svh */
// ivp_consts.svh: vector addresses, control bit positions and timing counts
// assumes: included by ivp_pkg and the design modules
`ifndef IVP_CONSTS_SVH
`define IVP_CONSTS_SVH
`define IVP_ADDR_W 12
`define IVP_NUM_SRC 32
`define IVP_RESET_VEC 12'h000
`define IVP_TABLE_BASE 12'h001
`define IVP_BOOT_RESET_ADDR 12'hC00
`define IVP_UNLOCK_BIT 0
`define IVP_RELOC_BIT 1
`define IVP_CTRL_RESET 8'h00
`define IVP_UNLOCK_CYCLES 4
`define IVP_SLOT_UNUSED 32'h60004000
`endif

/* File: core/ivp_pkg.sv */
// ivp_pkg: types for the vector placement block
// assumes: ivp_consts.svh is on the include path
`include "ivp_consts.svh"
package ivp_pkg;
  typedef logic [`IVP_ADDR_W-1:0] ivp_addr_type;
  typedef enum logic [1:0] {
    IVP_ST_IDLE = 2'b00,
    IVP_ST_UNLOCKED = 2'b01,
    IVP_ST_HOLDOFF = 2'b10
  } ivp_state_type;
endpackage

/* File: core/ivp_prio_if.sv */
// ivp_prio_if: pending requests in, winning slot out, between top and encoder
// assumes: one clock domain, combinational path
`timescale 1ns/1ps
`include "ivp_consts.svh"
interface ivp_prio_if;
  logic [`IVP_NUM_SRC-1:0] req;
  logic found;
  logic [4:0] slot;
  modport client (output req, input found, slot);
  modport encoder (input req, output found, slot);
endinterface

/* File: core/ivp_prio_enc.sv */
// ivp_prio_enc: lowest-numbered pending slot wins
// assumes: bit 0 of req is the reset slot and is never set
`timescale 1ns/1ps
`include "ivp_consts.svh"
module ivp_prio_enc (
  ivp_prio_if.encoder prio
);
  function automatic logic [5:0] ivp_lowest(input logic [`IVP_NUM_SRC-1:0] v);
    logic [5:0] r;
    r = 6'h00;
    for (int i = `IVP_NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, 5'(i)};
      end
    end
    return r;
  endfunction
  logic [5:0] res;
  always_comb begin
    res = ivp_lowest(prio.req);
  end
  assign prio.found = res[5];
  assign prio.slot = res[4:0];
endmodule // ivp_prio_enc

/* File: testbench/ivp_core_model.sv */
// ivp_core_model: core side, takes each offered vector as one fetch
// assumes: vector outputs are registered on the rising clock edge
`timescale 1ns/1ps
`include "ivp_consts.svh"
module ivp_core_model (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_vec_valid,
  input wire logic [`IVP_ADDR_W-1:0] i_vec_addr,
  output logic [`IVP_ADDR_W-1:0] o_fetch_addr,
  output logic [15:0] o_fetch_count
);
  // fetches only offered vectors; unused slots are never read
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_fetch_addr <= 12'h000;
      o_fetch_count <= 16'h0000;
    end else if (i_vec_valid) begin
      o_fetch_addr <= i_vec_addr;
      o_fetch_count <= o_fetch_count + 16'h0001;
    end
  end
endmodule // ivp_core_model

/* File: testbench/test_interrupt_vector_placement.sv */
// test_interrupt_vector_placement: directed tests of vector placement
// assumes: inputs driven at falling edge, core model on the vector outputs
`timescale 1ns/1ps
`include "ivp_consts.svh"
module test_interrupt_vector_placement;
  localparam logic [11:0] BOOT = 12'hC00;
  logic clk, rst_n, fuse, wr, done;
  logic [7:0] wdata, ctrl;
  logic [31:0] pend;
  logic [11:0] rvec, vaddr, faddr;
  logic valid, blk;
  logic [4:0] vslot;
  logic [15:0] fcnt;
  int errors = 0;
  int checked = 0;
  ivp_top #(.BOOT_RESET_ADDR(BOOT), .UNLOCK_CYCLES(4)) dut_u (.i_clk_sys(clk),
    .i_reset_n(rst_n), .i_boot_reset_select_fuse(fuse), .i_ctrl_wr(wr),
    .i_ctrl_wdata(wdata), .i_instr_done(done), .i_irq_pending(pend),
    .o_mcu_control_register(ctrl), .o_reset_vector(rvec), .o_vec_valid(valid),
    .o_vec_addr(vaddr), .o_vec_slot(vslot), .o_irq_blocked(blk));
  ivp_core_model core_u (.i_clk_sys(clk), .i_reset_n(rst_n), .i_vec_valid(valid),
    .i_vec_addr(vaddr), .o_fetch_addr(faddr), .o_fetch_count(fcnt));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s exp %h got %h", name, exp, got);
    end
  endtask
  task end_of_test;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task wr_ctrl(input logic [7:0] d);
    wr = 1'b1;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task reset_test;
    chk("rvec_unprog", 32'h000, rvec);
    fuse = 1'b0;
    repeat (2) @(negedge clk);
    chk("rvec_prog", BOOT, rvec);
    fuse = 1'b1;
    repeat (2) @(negedge clk);
  endtask
  task table_test(input logic [11:0] base);
    logic [15:0] c0;
    c0 = fcnt;
    for (int s = 1; s < 32; s++) begin
      pend = 32'h1 << s;
      @(negedge clk);
      chk("valid", !(s == 14 || s == 29 || s == 30), valid);
      if (valid === 1'b1) chk("slot", s, vslot);
      if (valid === 1'b1) chk("addr", base + s, vaddr);
      pend = 32'h0;
      @(negedge clk);
    end
    chk("fetches", c0 + 16'h001C, fcnt);
    chk("last_fetch", base + 12'h01F, faddr);
  endtask
  task prio_test;
    pend = 32'h8008_0400;
    @(negedge clk);
    chk("prio_a", 32'h00A, vaddr);
    pend = 32'h0000_4021;
    @(negedge clk);
    chk("prio_b", 32'h005, vaddr);
    pend = 32'h0000_0001;
    @(negedge clk);
    chk("reset_slot", 1'b0, valid);
    pend = 32'h6000_4000;
    @(negedge clk);
    chk("unused_slots", 1'b0, valid);
    pend = 32'h0;
    @(negedge clk);
  endtask
  task reloc_test(input logic [7:0] d);
    int n;
    pend = 32'h2;
    wr = 1'b1;
    wdata = 8'h01;
    #1 chk("blk_now", 1'b1, blk);
    @(negedge clk);
    chk("unlock", 8'h01, ctrl);
    wr_ctrl(d);
    chk("ctrl", d, ctrl);
    chk("held", 1'b0, valid);
    done = 1'b1;
    @(negedge clk);
    done = 1'b0;
    n = 0;
    while (blk === 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    chk("resume", base_of(d), vaddr);
    pend = 32'h0;
    @(negedge clk);
  endtask
  function automatic logic [31:0] base_of(input logic [7:0] d);
    return d[1] ? BOOT + 12'h001 : 12'h001;
  endfunction
  task reset_mid_test;
    rst_n = 1'b0;
    #1 chk("rst_ctrl", 8'h00, ctrl);
    chk("rst_valid", 1'b0, valid);
    chk("rst_addr", `IVP_TABLE_BASE, vaddr);
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    chk("rst_rvec", `IVP_RESET_VEC, rvec);
  endtask
  task timeout_test;
    wr_ctrl(8'h01);
    repeat (3) @(negedge clk);
    chk("blk_hold", 1'b1, blk);
    chk("unlock_hold", 8'h01, ctrl);
    @(negedge clk);
    chk("blk_end", 1'b0, blk);
    chk("unlock_clr", 8'h00, ctrl);
    wr_ctrl(8'h02);
    @(negedge clk);
    chk("no_unlock", 8'h00, ctrl);
  endtask
  initial begin
    rst_n = 1'b0;
    fuse = 1'b1;
    wr = 1'b0;
    wdata = 8'h00;
    done = 1'b0;
    pend = 32'h0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    reset_test();
    table_test(12'h000);
    prio_test();
    reloc_test(8'h02);
    table_test(BOOT);
    reset_mid_test();
    reloc_test(8'h00);
    timeout_test();
    end_of_test();
  end
  initial begin
    repeat (3000) @(posedge clk);
    errors++;
    end_of_test();
  end
endmodule // test_interrupt_vector_placement
